/* File: alu_right_shift_unit.sv */
// right-shift stage behind the alu: circular single and double, logical single
// assumes alu result, carry and overflow arrive from same-clock logic
module alu_right_shift_unit (
  input  wire logic        ref_clk,              // 25 mhz system clock
  input  wire logic        rst_n,                // synchronous reset, active low
  input  wire logic [7:0]  instr,                // instruction byte
  input  wire logic [31:0] alu_result,           // alu operation result
  input  wire logic        alu_carry,            // alu carry-out, pre-shift
  input  wire logic        alu_ovf,              // alu signed overflow
  input  wire logic [1:0]  word_cfg,             // 1, 2 or 4 byte words
  input  wire logic        shift_select_input,   // high: shifted value
  input  wire logic        word_fill_input_lane0,// low: fill a one
  input  wire logic        word_fill_input_lane1,
  input  wire logic        word_fill_input_lane2,
  input  wire logic        word_fill_input_lane3,
  input  wire logic        aux_load,             // load auxiliary register
  input  wire logic [31:0] aux_load_data,        // value for that load
  input  wire logic        dest_is_c,            // write via destination address
  input  wire logic        dest_is_b,            // write via operand b address
  output logic      [31:0] output_multiplexer,   // registered stage result
  output logic      [31:0] auxiliary_shift_register,
  output logic             rf_write,             // register file write strobe
  output rshift_pkg::status_t status             // registered flags
);
`include "rshift_defs.svh"
  // select and fill pins are synchronised before use
  // the two-flop stage costs two cycles of lag, so the controller must settle
  // select and fill two edges ahead of the instruction that they qualify
  // the idle value is select high and fill high, which reads as a shift with
  // a zero fill, the same as a floating pin would give
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_s1 <= `RS_PIN_IDLE;
      pin_s2 <= `RS_PIN_IDLE;
    end else begin
      pin_s1 <= {shift_select_input, word_fill_input_lane3, word_fill_input_lane2,
                 word_fill_input_lane1, word_fill_input_lane0};
      pin_s2 <= pin_s1;
    end
  end
  wire logic       sel = pin_s2[4];          // synchronised select
  wire logic [3:0] fill_n = pin_s2[3:0];     // synchronised fill pins

  // the alu op nibble is not decoded here: the alu upstream has already
  // acted on it, and this stage only sees its result
  // any upper-nibble code outside the three shift codes passes the result
  // through unshifted, so an unknown code never corrupts the datapath
  // shift function from upper nibble
  wire logic [3:0] fcode = instr[`RS_FUNC_HI:`RS_FUNC_LO];
  rshift_pkg::shift_fn_t fn;
  assign fn = (fcode == `RS_CODE_CIRC_SINGLE) ? rshift_pkg::FN_CIRC_S :
              (fcode == `RS_CODE_CIRC_DOUBLE) ? rshift_pkg::FN_CIRC_D :
              (fcode == `RS_CODE_LOGIC_SINGLE) ? rshift_pkg::FN_LOGIC_S :
              rshift_pkg::FN_NONE;

  // per-word feeds; shifters run in parallel
  // both shifters always compute; the decode below only picks what each
  // word's top bit receives, which keeps the function decode off the data
  // path and makes the three shifts cost the same
  logic [3:0]  alu_low;
  logic [3:0]  aux_low;
  logic [3:0]  alu_top;
  logic [3:0]  aux_top;
  logic [31:0] alu_sh;
  logic [31:0] aux_sh;
  // the alu result is the shifter input, so the shift follows the alu op
  lane_shifter u_alu_sh (
    .din     (alu_result),
    .cfg     (word_cfg),
    .top_in  (alu_top),
    .dout    (alu_sh),
    .low_out (alu_low)
  );
  // auxiliary register is the lower half of a double word
  lane_shifter u_aux_sh (
    .din     (auxiliary_shift_register),
    .cfg     (word_cfg),
    .top_in  (aux_top),
    .dout    (aux_sh),
    .low_out (aux_low)
  );
  // top-bit feed: own lsb, partner lsb, or fill value
  always_comb begin
    unique case (fn)
      rshift_pkg::FN_CIRC_S:  alu_top = alu_low;
      rshift_pkg::FN_CIRC_D:  alu_top = aux_low;
      rshift_pkg::FN_LOGIC_S: alu_top = ~fill_n;   // lsb dropped
      default:                alu_top = 4'h0;
    endcase
  end
  assign aux_top = alu_low;

  // select low, or a code that is not a shift, passes the alu result
  wire logic do_shift = (fn != rshift_pkg::FN_NONE) && sel;
  wire logic [31:0] next_y = do_shift ? alu_sh : alu_result;
  wire logic aux_step = (fn == rshift_pkg::FN_CIRC_D) && sel;

  // msb of the configured word for negative flag
  wire logic msb = (word_cfg == `RS_CFG_8) ? next_y[7] :
                   (word_cfg == `RS_CFG_16) ? next_y[15] : next_y[31];
  wire logic [31:0] width_mask = (word_cfg == `RS_CFG_8) ? 32'h0000_00ff :
                                 (word_cfg == `RS_CFG_16) ? 32'h0000_ffff : 32'hffff_ffff;
  // overflow is taken from the alu and then qualified by the shift: a shift
  // that changes the bit in the sign position makes the alu's overflow
  // meaningless for the stored word, so it is dropped there
  // limitation: only the lowest configured word feeds zero, negative and
  // overflow; per-word status would need one flag set per lane
  // a rotate or fill can flip the sign, so overflow looks at both stages
  wire logic sign_moved = do_shift && (msb != ((word_cfg == `RS_CFG_8) ? alu_result[7] :
                          (word_cfg == `RS_CFG_16) ? alu_result[15] : alu_result[31]));
  rshift_pkg::status_t next_status;
  assign next_status.zero  = ((next_y & width_mask) == 32'h0);
  assign next_status.neg   = msb;
  assign next_status.ovf   = alu_ovf ^ (alu_ovf & sign_moved);
  assign next_status.carry = alu_carry;

  // output and flags register
  // everything leaves through flip-flops so the next stage sees one clean
  // value per cycle, however the alu result path settles
  // the write strobe refuses the operand b address even when both are asked
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      output_multiplexer <= `RS_Y_RESET;
      status             <= '0;
      rf_write           <= 1'b0;
    end else begin
      output_multiplexer <= next_y;
      status             <= next_status;
      rf_write           <= dest_is_c && !dest_is_b;
    end
  end
  // auxiliary register: loads, rotates, or holds
  // a rotate wins over a load in the same cycle, so a double shift never
  // loses the bit that it carries across from the alu half
  // with select low a double shift does not rotate the register, which loads or holds
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      auxiliary_shift_register <= `RS_AUX_RESET;
    end else if (aux_step) begin
      auxiliary_shift_register <= aux_sh;
    end else if (aux_load) begin
      auxiliary_shift_register <= aux_load_data;
    end
  end

  // checks
  // every assertion runs on the stage clock and is muted while reset is
  // asserted; select and fill terms use the synchronised copies, since
  // those are what the datapath really acts on
  // carry is the alu's own, untouched by any shift
  property p_carry;
    @(posedge ref_clk) disable iff (!rst_n) 1'b1 |=> status.carry == $past(alu_carry);
  endproperty
  a_carry: assert property (p_carry) else $error("carry not pre-shift");
  // a double shift with select low must not move the auxiliary register
  property p_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (fn == rshift_pkg::FN_CIRC_D && !sel && !aux_load) |=>
      $stable(auxiliary_shift_register);
  endproperty
  a_hold: assert property (p_hold) else $error("aux changed");
  // select low hands the alu result straight to the output
  property p_pass;
    @(posedge ref_clk) disable iff (!rst_n) !sel |=> output_multiplexer == $past(alu_result);
  endproperty
  a_pass: assert property (p_pass) else $error("unshifted pass failed");
  // full-word rotate: bit 0 wraps round to bit 31
  property p_circ;
    @(posedge ref_clk) disable iff (!rst_n)
      (sel && fn == rshift_pkg::FN_CIRC_S && word_cfg == `RS_CFG_32) |=>
      output_multiplexer == {$past(alu_result[0]), $past(alu_result[31:1])};
  endproperty
  a_circ: assert property (p_circ) else $error("rotate wrong");
  // full-word logical shift: the fill lane decides the new top bit
  property p_logic;
    @(posedge ref_clk) disable iff (!rst_n)
      (sel && fn == rshift_pkg::FN_LOGIC_S && word_cfg == `RS_CFG_32) |=>
      output_multiplexer == {~$past(fill_n[0]), $past(alu_result[31:1])};
  endproperty
  a_logic: assert property (p_logic) else $error("logical shift wrong");
  // double rotate: each half feeds its low bit into the other's top bit
  property p_dbl;
    @(posedge ref_clk) disable iff (!rst_n)
      (sel && fn == rshift_pkg::FN_CIRC_D && word_cfg == `RS_CFG_32) |=>
      auxiliary_shift_register[31] == $past(alu_result[0]) &&
      output_multiplexer[31] == $past(auxiliary_shift_register[0]);
  endproperty
  a_dbl: assert property (p_dbl) else $error("double rotate wrong");
  // zero flag follows the stored result, not the alu input
  property p_zero;
    @(posedge ref_clk) disable iff (!rst_n)
      (word_cfg == `RS_CFG_32) |=> status.zero == (output_multiplexer == 32'h0);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  // any decoded shift with select high reaches the output
  property p_fwd;
    @(posedge ref_clk) disable iff (!rst_n)
      (sel && fn != rshift_pkg::FN_NONE) |=> output_multiplexer == $past(alu_sh);
  endproperty
  a_fwd: assert property (p_fwd) else $error("shift not forwarded");
  // with no shift the alu overflow reaches the flag untouched
  property p_ovf_pass;
    @(posedge ref_clk) disable iff (!rst_n) !sel |=> status.ovf == $past(alu_ovf);
  endproperty
  a_ovf_pass: assert property (p_ovf_pass) else $error("overflow not passed");
  // a rotate that keeps the sign bit keeps a pending overflow
  property p_ovf_keep;
    @(posedge ref_clk) disable iff (!rst_n)
      (sel && fn == rshift_pkg::FN_CIRC_S && word_cfg == `RS_CFG_32 &&
       alu_result[0] == alu_result[31]) |=> status.ovf == $past(alu_ovf);
  endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow lost");
  // negative flag is the stored word's top bit
  property p_neg;
    @(posedge ref_clk) disable iff (!rst_n)
      (word_cfg == `RS_CFG_32) |=> status.neg == output_multiplexer[31];
  endproperty
  a_neg: assert property (p_neg) else $error("negative flag wrong");
  // byte words: flags come from the lowest byte after the shift
  property p_flags8;
    @(posedge ref_clk) disable iff (!rst_n)
      (word_cfg == `RS_CFG_8) |=>
      status.neg == output_multiplexer[7] &&
      status.zero == (output_multiplexer[7:0] == 8'h00);
  endproperty
  a_flags8: assert property (p_flags8) else $error("byte flags wrong");
  // the operand b address never receives the shifted result
  property p_no_b;
    @(posedge ref_clk) disable iff (!rst_n) dest_is_b |=> !rf_write;
  endproperty
  a_no_b: assert property (p_no_b) else $error("write via operand b");
  // the destination address alone does write
  property p_write_c;
    @(posedge ref_clk) disable iff (!rst_n) (dest_is_c && !dest_is_b) |=> rf_write;
  endproperty
  a_write_c: assert property (p_write_c) else $error("destination write missing");
  // byte words rotate each byte on its own
  property p_circ8;
    @(posedge ref_clk) disable iff (!rst_n)
      (sel && fn == rshift_pkg::FN_CIRC_S && word_cfg == `RS_CFG_8) |=>
      output_multiplexer[7] == $past(alu_result[0]) &&
      output_multiplexer[15] == $past(alu_result[8]) &&
      output_multiplexer[23] == $past(alu_result[16]) &&
      output_multiplexer[31] == $past(alu_result[24]);
  endproperty
  a_circ8: assert property (p_circ8) else $error("byte rotate wrong");
  // halfword logical shift drops each word's lsb and fills per lane
  property p_drop16;
    @(posedge ref_clk) disable iff (!rst_n)
      (sel && fn == rshift_pkg::FN_LOGIC_S && word_cfg == `RS_CFG_16) |=>
      output_multiplexer[14:0] == $past(alu_result[15:1]) &&
      output_multiplexer[30:16] == $past(alu_result[31:17]) &&
      output_multiplexer[15] == !$past(fill_n[0]) &&
      output_multiplexer[31] == !$past(fill_n[1]);
  endproperty
  a_drop16: assert property (p_drop16) else $error("halfword drop wrong");
  // the auxiliary half moves one place right with the alu half
  property p_aux_rot;
    @(posedge ref_clk) disable iff (!rst_n)
      (sel && fn == rshift_pkg::FN_CIRC_D && word_cfg == `RS_CFG_32) |=>
      auxiliary_shift_register[30:0] == $past(auxiliary_shift_register[31:1]);
  endproperty
  a_aux_rot: assert property (p_aux_rot) else $error("aux not rotated");
  // the alu result forms the upper half and shifts as one with it
  property p_dbl_low;
    @(posedge ref_clk) disable iff (!rst_n)
      (sel && fn == rshift_pkg::FN_CIRC_D && word_cfg == `RS_CFG_32) |=>
      output_multiplexer[30:0] == $past(alu_result[31:1]);
  endproperty
  a_dbl_low: assert property (p_dbl_low) else $error("upper half wrong");
  // a code that is no shift passes the result as it is
  property p_none;
    @(posedge ref_clk) disable iff (!rst_n)
      (fn == rshift_pkg::FN_NONE) |=> output_multiplexer == $past(alu_result);
  endproperty
  a_none: assert property (p_none) else $error("unknown code shifted");
  // a load lands whenever no double rotate claims the register
  property p_load;
    @(posedge ref_clk) disable iff (!rst_n)
      (aux_load && !(sel && fn == rshift_pkg::FN_CIRC_D)) |=>
      auxiliary_shift_register == $past(aux_load_data);
  endproperty
  a_load: assert property (p_load) else $error("aux load lost");
  // select low in a double shift leaves the output unshifted
  property p_dbl_off;
    @(posedge ref_clk) disable iff (!rst_n)
      (!sel && fn == rshift_pkg::FN_CIRC_D) |=> output_multiplexer == $past(alu_result);
  endproperty
  a_dbl_off: assert property (p_dbl_off) else $error("double pass wrong");
  c_circ_s: cover property (@(posedge ref_clk) sel && fn == rshift_pkg::FN_CIRC_S);
  c_circ_d: cover property (@(posedge ref_clk) sel && fn == rshift_pkg::FN_CIRC_D);
  c_logic:  cover property (@(posedge ref_clk) sel && fn == rshift_pkg::FN_LOGIC_S);
  // the unshifted pass of a decoded shift, and the narrowest word size
  c_pass:   cover property (@(posedge ref_clk) !sel && fn != rshift_pkg::FN_NONE);
  c_byte:   cover property (@(posedge ref_clk)
    sel && fn == rshift_pkg::FN_LOGIC_S && word_cfg == `RS_CFG_8);
endmodule : alu_right_shift_unit

/* File: ctrl_model.sv */
// controller stand-in: encodes shift codes and fill lanes for the right-shift stage
// assumes the bench supplies the wanted function and top bits each cycle
module ctrl_model (
  input  wire logic [3:0] code,     // shift function code
  input  wire logic [3:0] op,       // alu operation nibble
  input  wire logic [3:0] want_one, // words that need a one on top
  output logic      [7:0] instr,    // instruction byte
  output logic      [3:0] fill_n    // fill lanes, low asks for a one
);
  timeunit 1ns;
  timeprecision 1ps;
  // shift code rides the upper nibble, alu op the lower
  assign instr = {code, op};
  // a one on top is asked for by pulling the lane low; lanes rest high
  assign fill_n = ~want_one;
endmodule : ctrl_model

/* File: lane_shifter.sv */
// one-position right shift of a 32-bit value split into 1, 2 or 4 byte words
// assumes the caller supplies per-word top-bit feed values
module lane_shifter (
  input  wire logic [31:0] din,      // value to shift
  input  wire logic [1:0]  cfg,      // word size selector
  input  wire logic [3:0]  top_in,   // bit fed into each word's top
  output logic      [31:0] dout,     // shifted value
  output logic      [3:0]  low_out   // bit 0 of each word
);
`include "rshift_defs.svh"
  // word index of byte b under the current configuration
  function automatic logic [1:0] word_of(input logic [1:0] b, input logic [1:0] c);
    word_of = (c == `RS_CFG_32) ? 2'h0 : (c == `RS_CFG_16) ? {1'b0, b[1]} : b;
  endfunction : word_of
  // true when byte b is the top byte of its word
  function automatic logic is_top(input logic [1:0] b, input logic [1:0] c);
    is_top = (c == `RS_CFG_32) ? (b == 2'h3) : (c == `RS_CFG_16) ? b[0] : 1'b1;
  endfunction : is_top
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_byte
      wire logic [1:0] bi = 2'(b);
      wire logic       from_above = (b < 3) ? din[(b < 3 ? 8*b+8 : 0)] : 1'b0;
      // top bit of a byte comes from the byte above unless it tops a word
      assign dout[8*b+7] = is_top(bi, cfg) ? top_in[word_of(bi, cfg)] : from_above;
      assign dout[8*b+6 -: 7] = din[8*b+7 -: 7];
    end
  endgenerate
  // lowest bit of each word, indexed by word number
  assign low_out[0] = din[0];
  assign low_out[1] = (cfg == `RS_CFG_32) ? 1'b0 : (cfg == `RS_CFG_16) ? din[16] : din[8];
  assign low_out[2] = (cfg == `RS_CFG_8) ? din[16] : 1'b0;
  assign low_out[3] = (cfg == `RS_CFG_8) ? din[24] : 1'b0;
endmodule : lane_shifter

/* File: rshift_defs.svh */
// constants for the right-shift stage of the registered alu slice
// assumes one 25 mhz clock and a microcoded controller on the same clock
`ifndef RSHIFT_DEFS_SVH
`define RSHIFT_DEFS_SVH
`define RS_CODE_CIRC_SINGLE 4'h8
`define RS_CODE_CIRC_DOUBLE 4'h9
`define RS_CODE_LOGIC_SINGLE 4'h2
`define RS_CFG_8 2'h0
`define RS_CFG_16 2'h1
`define RS_CFG_32 2'h2
`define RS_AUX_RESET 32'h0000_0000
`define RS_Y_RESET 32'h0000_0000
`define RS_PIN_IDLE 5'h1f
`define RS_ALU_LO 3
`define RS_ALU_HI 0
`define RS_FUNC_LO 4
`define RS_FUNC_HI 7
`endif

/* File: rshift_pkg.sv */
// types shared by the right-shift stage and its testbench
// assumes rshift_defs.svh is compiled alongside
package rshift_pkg;
  // shift function decoded from the upper instruction nibble
  typedef enum logic [3:0] {
    FN_NONE   = 4'h1,
    FN_CIRC_S = 4'h2,
    FN_CIRC_D = 4'h4,
    FN_LOGIC_S= 4'h8
  } shift_fn_t;
  // status flags carried together
  typedef struct packed {
    logic zero;
    logic neg;
    logic ovf;
    logic carry;
  } status_t;
endpackage : rshift_pkg

/* File: test_alu_right_shift_unit.sv */
// self-checking bench for the right-shift stage, random steps plus corner cases
// assumes ctrl_model drives instruction and fill lanes; select lags two edges
module test_alu_right_shift_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst_n, alu_carry, alu_ovf, sel, aux_load, dest_is_c, dest_is_b, rf_write;
  logic [3:0]  code, op, want, fill_n;   // controller requests
  logic [7:0]  instr;                    // encoded instruction
  logic [1:0]  word_cfg;                 // word size
  logic [31:0] alu_result, aux_load_data, y, aux;
  rshift_pkg::status_t status;           // registered flags
  int          errors, n_checks, seed;
  ctrl_model ctrl_model_inst (.code(code), .op(op), .want_one(want), .instr(instr),
    .fill_n(fill_n));
  alu_right_shift_unit alu_right_shift_unit_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .instr(instr), .alu_result(alu_result), .alu_carry(alu_carry), .alu_ovf(alu_ovf),
    .word_cfg(word_cfg), .shift_select_input(sel), .word_fill_input_lane0(fill_n[0]),
    .word_fill_input_lane1(fill_n[1]), .word_fill_input_lane2(fill_n[2]),
    .word_fill_input_lane3(fill_n[3]), .aux_load(aux_load), .aux_load_data(aux_load_data),
    .dest_is_c(dest_is_c), .dest_is_b(dest_is_b), .output_multiplexer(y),
    .auxiliary_shift_register(aux), .rf_write(rf_write), .status(status));
  // one-place right shift inside each word, top bits fed per word
  function automatic logic [31:0] rsh(input logic [31:0] d, input logic [1:0] c,
                                      input logic [3:0] top);
    logic [31:0] r;
    int w;
    w = 8 << c;
    for (int b = 0; b < 32; b++) r[b] = ((b % w) == w - 1) ? top[b / w] : d[b + 1];
    return r;
  endfunction : rsh
  // bit 0 of each word, unused lanes zero
  function automatic logic [3:0] lows(input logic [31:0] d, input logic [1:0] c);
    logic [3:0] l;
    for (int i = 0; i < 4; i++) l[i] = (i * (8 << c) < 32) ? d[i * (8 << c)] : 1'b0;
    return l;
  endfunction : lows
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  // load aux and settle select and fill under a pass code, then one real instruction
  task automatic step(input logic [3:0] c, input logic [1:0] cf, input logic s,
                      input logic [3:0] wo, input logic [31:0] a, input logic [31:0] ld);
    logic [31:0] e_y, e_aux, mask;
    int w;
    w = 8 << cf;
    @(negedge ref_clk);
    code = 4'h0;
    word_cfg = cf;
    sel = s;
    want = wo;
    alu_result = a;
    op = 4'($random(seed));
    aux_load = 1'b1;
    aux_load_data = ld;
    alu_carry = 1'($random(seed));
    alu_ovf = 1'($random(seed));
    dest_is_c = 1'($random(seed));
    dest_is_b = 1'($random(seed));
    @(negedge ref_clk);
    aux_load = 1'b0;
    @(negedge ref_clk);
    code = c;
    // a load in the shift cycle must lose to a double rotate
    aux_load = ld[4];
    aux_load_data = ~ld;
    @(negedge ref_clk);
    e_y = a;
    e_aux = ld[4] ? ~ld : ld;
    // select low leaves the result unshifted and aux only loaded or held
    if (s) begin
      case (c)
        4'h8: e_y = rsh(a, cf, lows(a, cf));
        4'h9: begin
          e_y = rsh(a, cf, lows(ld, cf));
          e_aux = rsh(ld, cf, lows(a, cf));
        end
        4'h2: e_y = rsh(a, cf, wo);
        default: ;
      endcase
    end
    mask = (w == 32) ? 32'hffff_ffff : (32'h1 << w) - 32'h1;
    chk("y", e_y, y);
    chk("aux", e_aux, aux);
    chk("zero", {31'h0, (e_y & mask) == 32'h0}, {31'h0, status.zero});
    chk("neg", {31'h0, e_y[w - 1]}, {31'h0, status.neg});
    chk("carry", {31'h0, alu_carry}, {31'h0, status.carry});
    chk("rf_write", {31'h0, dest_is_c & ~dest_is_b}, {31'h0, rf_write});
    // overflow survives unless the shift moved the sign of the word
    chk("ovf", {31'h0, alu_ovf & (e_y[w - 1] == a[w - 1])}, {31'h0, status.ovf});
    code = 4'h0;
    aux_load = 1'b0;
  endtask : step
  // free-running 25 mhz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // watchdog: about 1230 cycles expected, cut off well past that
  initial begin
    #400000;
    errors++;
    conclude();
  end
  // main sequence: reset, corner cases, then random steps
  initial begin
    logic [3:0] codes [4];
    codes = '{4'h8, 4'h9, 4'h2, 4'h5};
    seed = 4;
    errors = 0;
    n_checks = 0;
    rst_n = 1'b0;
    code = 4'h0;
    op = 4'h0;
    want = 4'h0;
    word_cfg = 2'h2;
    sel = 1'b1;
    alu_result = 32'h0;
    alu_carry = 1'b0;
    alu_ovf = 1'b0;
    aux_load = 1'b0;
    aux_load_data = 32'h0;
    dest_is_c = 1'b0;
    dest_is_b = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk("reset", 32'h0, y | aux | {28'h0, status} | {31'h0, rf_write});
    rst_n = 1'b1;
    step(4'h8, 2'h2, 1'b1, 4'h0, 32'h3788_c618, 32'h1234_5678);
    step(4'h9, 2'h2, 1'b1, 4'h0, 32'h3788_c618, 32'h50a9_9a0f);
    step(4'h9, 2'h2, 1'b0, 4'h0, 32'h3788_c618, 32'h50a9_9a0f);
    step(4'h2, 2'h0, 1'b1, 4'ha, 32'h0000_0101, 32'h0);
    step(4'h2, 2'h1, 1'b1, 4'h1, 32'h0001_0001, 32'h0);
    step(4'h8, 2'h0, 1'b0, 4'h0, 32'h8000_0001, 32'h0);
    for (int i = 0; i < 300; i++)
      step(codes[i % 4], 2'($unsigned($random(seed)) % 3), 1'($random(seed)),
           4'($random(seed)), $random(seed), $random(seed));
    conclude();
  end
endmodule : test_alu_right_shift_unit
